// ===== rtl/scspll_ctrl.sv
// System clock source selection and system PLL control registers.
// Assumes software unlock is signalled by WR_UNLOCK_I, source ready flags
// from the analog side, and a clock monitor failure pulse.
`timescale 1ns/10ps
`default_nettype none

module scspll_ctrl (
   input  wire logic                       MCLK_I,
   input  wire logic                       RST_N_I,
   input  wire logic [11:0]                ADDR_I,
   input  wire logic [31:0]                WDATA_I,
   input  wire logic                       WR_I,
   input  wire logic                       RD_I,
   output logic      [31:0]                RDATA_O,
   input  wire logic                       WR_UNLOCK_I,
   input  wire scspll_pkg::scspll_fuse_s   FUSE_I,
   input  wire scspll_pkg::scspll_rdy_s    SRC_RDY_I,
   input  wire logic                       CLK_FAIL_I,
   input  wire logic                       WAIT_EXEC_I,
   output logic                            SLEEP_ENTER_O,
   output logic                            IDLE_ENTER_O,
   output logic      [2:0]                 CLK_MUX_SEL_O,
   output logic                            CLK_MUX_PARK_O,
   output logic      [7:0]                 FRC_DIV_RATIO_O,
   output logic      [7:0]                 PLL_OUT_DIV_O,
   output logic      [4:0]                 PLL_MULT_O,
   output logic                            PLL_IN_FRC_O,
   output logic                            SECONDARY_OSCILLATOR_EN_O,
   output logic                            SWITCH_BUSY_O
);

   logic [2:0]  frc_div_r;
   logic [2:0]  cur_src_r;
   logic [2:0]  req_src_r;
   logic        lock_r;
   logic        sleep_r;
   logic        fail_r;
   logic        secondary_oscillator_r;
   logic        swreq_r;
   logic [2:0]  pll_odiv_r;
   logic [6:0]  pll_mult_r;
   logic        pll_iclk_r;
   logic        fuse_done_r;
   scspll_pkg::scspll_sw_e sw_st_r;
   logic [1:0]  gap_cnt_r;
   logic [2:0]  tgt_src_r;

   logic        osc_hit;
   logic        pll_hit;
   logic [31:0] osc_cur;
   logic [31:0] pll_cur;
   logic [31:0] osc_nxt;
   logic [31:0] pll_nxt;
   logic        osc_wr;
   logic        pll_wr;
   logic [2:0]  req_eff;
   logic        tgt_rdy;

   // Low nibble picks the plain, clear, set or invert view of each word
   assign osc_hit = (ADDR_I[11:4] == scspll_pkg::OSC_CTRL_OFS[11:4]);
   assign pll_hit = (ADDR_I[11:4] == scspll_pkg::PLL_CTRL_OFS[11:4]);

   // Unimplemented positions are zero in the packed images
   always_comb begin
      osc_cur = 32'h0000_0000;
      osc_cur[scspll_pkg::FAST_RC_DIVIDER_LSB +: 3] = frc_div_r;
      osc_cur[scspll_pkg::CURSRC_LSB +: 3] = cur_src_r;
      osc_cur[scspll_pkg::REQSRC_LSB +: 3] = req_src_r;
      osc_cur[scspll_pkg::LOCK_BIT]        = lock_r;
      osc_cur[scspll_pkg::SLEEP_BIT]       = sleep_r;
      osc_cur[scspll_pkg::FAIL_BIT]        = fail_r;
      osc_cur[scspll_pkg::SECONDARY_OSC_ENABLE_BIT]      = secondary_oscillator_r;
      osc_cur[scspll_pkg::SWREQ_BIT]       = swreq_r;
      pll_cur = 32'h0000_0000;
      pll_cur[scspll_pkg::PODIV_LSB +: 3]  = pll_odiv_r;
      pll_cur[scspll_pkg::PMULT_LSB +: 7]  = pll_mult_r;
      pll_cur[scspll_pkg::PICLK_BIT]       = pll_iclk_r;
   end

   // Alias decode applied to whichever register is addressed
   function automatic logic [31:0] alias_apply(input logic [31:0] cur,
                                               input logic [31:0] wd,
                                               input logic [3:0]  sub);
      logic [31:0] r;
      r = wd;
      if (sub == scspll_pkg::ALIAS_CLR) begin
         r = cur & ~wd;
      end else if (sub == scspll_pkg::ALIAS_SET) begin
         r = cur | wd;
      end else if (sub == scspll_pkg::ALIAS_INV) begin
         r = cur ^ wd;
      end
      return r;
   endfunction

   assign osc_nxt = alias_apply(osc_cur, WDATA_I, ADDR_I[3:0]);
   assign pll_nxt = alias_apply(pll_cur, WDATA_I, ADDR_I[3:0]);
   // A write without the unlock level is dropped silently, no error flag
   // Lock gates the whole PLL word, not single fields
   assign osc_wr  = WR_I && osc_hit && WR_UNLOCK_I;
   assign pll_wr  = WR_I && pll_hit && WR_UNLOCK_I && !lock_r;

   // Fuse straps are caught on the first clock after release
   // Bus traffic in that first clock is not expected, so fuse loads take priority
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fuse_done_r <= 1'b0;
      end else begin
         fuse_done_r <= 1'b1;
      end
   end

   // Divider and sleep choice stay writable under lock; source and switch requests and the whole PLL word freeze
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         frc_div_r <= scspll_pkg::FAST_RC_DIVIDER_RST;
         sleep_r   <= 1'b0;
         lock_r    <= 1'b0;
      end else if (osc_wr) begin
         frc_div_r <= osc_nxt[scspll_pkg::FAST_RC_DIVIDER_LSB +: 3];
         sleep_r   <= osc_nxt[scspll_pkg::SLEEP_BIT];
         // Lock is sticky until reset so a runaway write cannot unlock
         lock_r    <= lock_r | osc_nxt[scspll_pkg::LOCK_BIT];
      end
   end

   // Requested source and secondary enable take fuse values after release
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         req_src_r <= scspll_pkg::SRC_FRC_DIV;
         secondary_oscillator_r    <= 1'b0;
      end else if (!fuse_done_r) begin
         req_src_r <= FUSE_I.initial_source;
         secondary_oscillator_r    <= FUSE_I.secondary_oscillator_enable;
      end else if (osc_wr) begin
         if (!lock_r) begin
            req_src_r <= osc_nxt[scspll_pkg::REQSRC_LSB +: 3];
         end
         secondary_oscillator_r    <= osc_nxt[scspll_pkg::SECONDARY_OSC_ENABLE_BIT];
      end
   end

   // Hardware set wins over a software clear in the same cycle
   // A clear racing a monitor event would otherwise lose the failure
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fail_r <= 1'b0;
      end else if (CLK_FAIL_I) begin
         fail_r <= 1'b1;
      end else if (osc_wr) begin
         fail_r <= osc_nxt[scspll_pkg::FAIL_BIT];
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pll_odiv_r <= scspll_pkg::PODIV_RST;
         pll_mult_r <= scspll_pkg::PMULT_RST;
         pll_iclk_r <= 1'b0;
      end else if (!fuse_done_r) begin
         pll_iclk_r <= FUSE_I.pll_source;
      end else if (pll_wr) begin
         pll_odiv_r <= pll_nxt[scspll_pkg::PODIV_LSB +: 3];
         pll_mult_r <= pll_nxt[scspll_pkg::PMULT_LSB +: 7];
         pll_iclk_r <= pll_nxt[scspll_pkg::PICLK_BIT];
      end
   end

   // Codes 110/111 fold onto the divided fast RC; 011 is kept as is
   always_comb begin
      req_eff = req_src_r;
      if (req_src_r[2:1] == 2'b11) begin
         req_eff = scspll_pkg::SRC_FRC_DIV;
      end
   end

   // Ready flags are taken as synchronous; the analog side must clean them up
   always_comb begin
      unique case (tgt_src_r)
         scspll_pkg::SRC_FRC_DIV: tgt_rdy = SRC_RDY_I.fast_rc_oscillator;
         scspll_pkg::SRC_PLL:     tgt_rdy = SRC_RDY_I.pll;
         scspll_pkg::SRC_PRIMARY_OSCILLATOR:    tgt_rdy = SRC_RDY_I.primary_oscillator;
         scspll_pkg::SRC_SECONDARY_OSCILLATOR:    tgt_rdy = SRC_RDY_I.secondary_oscillator;
         scspll_pkg::SRC_LOW_POWER_RC_OSCILLATOR:    tgt_rdy = SRC_RDY_I.low_power_rc_oscillator;
         // Reserved 011 never becomes ready, the switch stays pending
         default:                 tgt_rdy = 1'b0;
      endcase
   end

   // Switch sequencer; request bit loaded from two-speed fuse on the first clock after release
   // The gap keeps the mux parked so no runt pulse reaches the system clock
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         swreq_r   <= 1'b0;
         sw_st_r   <= scspll_pkg::SW_IDLE;
         gap_cnt_r <= 2'h0;
         tgt_src_r <= scspll_pkg::SRC_FRC_DIV;
         cur_src_r <= scspll_pkg::SRC_FRC_DIV;
      end else if (!fuse_done_r) begin
         swreq_r   <= FUSE_I.two_speed_startup;
         cur_src_r <= scspll_pkg::SRC_FRC_DIV;
      end else begin
         unique case (sw_st_r)
            scspll_pkg::SW_IDLE: begin
               if (osc_wr && !lock_r && osc_nxt[scspll_pkg::SWREQ_BIT]) begin
                  swreq_r <= 1'b1;
               end
               if (swreq_r) begin
                  tgt_src_r <= req_eff;
                  sw_st_r   <= scspll_pkg::SW_WAIT_RDY;
               end
            end
            scspll_pkg::SW_WAIT_RDY: begin
               if (tgt_rdy) begin
                  gap_cnt_r <= 2'(scspll_pkg::SWITCH_GAP_CYC);
                  sw_st_r   <= scspll_pkg::SW_GAP;
               end
            end
            scspll_pkg::SW_GAP: begin
               if (gap_cnt_r == 2'h1) begin
                  cur_src_r <= tgt_src_r;
                  sw_st_r   <= scspll_pkg::SW_DONE;
               end
               gap_cnt_r <= gap_cnt_r - 2'h1;
            end
            scspll_pkg::SW_DONE: begin
               swreq_r <= 1'b0;
               sw_st_r <= scspll_pkg::SW_IDLE;
            end
         endcase
      end
   end

   // Ratio outputs as one-hot powers of two; code 7 sits on bit 7 and stands for 128
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FRC_DIV_RATIO_O <= 8'h01;
         PLL_OUT_DIV_O   <= 8'h01;
      end else begin
         FRC_DIV_RATIO_O <= (frc_div_r == 3'h7) ? 8'h80 : 8'(1 << frc_div_r);
         PLL_OUT_DIV_O   <= (pll_odiv_r == 3'h7) ? 8'h80 : 8'(1 << pll_odiv_r);
      end
   end

   // Multiplier as a plain factor, never an undefined ratio to the analog side
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PLL_MULT_O <= 5'h03;
      end else begin
         unique case (pll_mult_r)
            7'h00:   PLL_MULT_O <= 5'h02;
            7'h01:   PLL_MULT_O <= 5'h03;
            7'h02:   PLL_MULT_O <= 5'h04;
            7'h03:   PLL_MULT_O <= 5'h06;
            7'h04:   PLL_MULT_O <= 5'h08;
            7'h05:   PLL_MULT_O <= 5'h0C;
            7'h06:   PLL_MULT_O <= 5'h18;
            // Reserved codes hold the previous factor
            default: PLL_MULT_O <= PLL_MULT_O;
         endcase
      end
   end

   // Input select follows its control bit one clock later; the PLL must be idle when it moves
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PLL_IN_FRC_O <= 1'b0;
      end else begin
         PLL_IN_FRC_O <= pll_iclk_r;
      end
   end

   // Mux select trails the current-source field by one clock
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         CLK_MUX_SEL_O  <= scspll_pkg::SRC_FRC_DIV;
         CLK_MUX_PARK_O <= 1'b0;
      end else begin
         CLK_MUX_SEL_O  <= cur_src_r;
         CLK_MUX_PARK_O <= (sw_st_r == scspll_pkg::SW_GAP);
      end
   end

   // Enables follow their control bits one clock later
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SECONDARY_OSCILLATOR_EN_O     <= 1'b0;
         SWITCH_BUSY_O <= 1'b0;
      end else begin
         SECONDARY_OSCILLATOR_EN_O     <= secondary_oscillator_r;
         SWITCH_BUSY_O <= swreq_r;
      end
   end

   // One-clock entry strobes, only ever one of the two
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SLEEP_ENTER_O <= 1'b0;
         IDLE_ENTER_O  <= 1'b0;
      end else begin
         SLEEP_ENTER_O <= WAIT_EXEC_I && sleep_r;
         IDLE_ENTER_O  <= WAIT_EXEC_I && !sleep_r;
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   // Alias addresses are write-only views and read back as zero
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= 32'h0000_0000;
      end else if (RD_I && osc_hit && ADDR_I[3:0] == 4'h0) begin
         RDATA_O <= osc_cur;
      end else if (RD_I && pll_hit && ADDR_I[3:0] == 4'h0) begin
         RDATA_O <= pll_cur;
      end else begin
         RDATA_O <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// ===== rtl/scspll_pkg.sv
// Package for the system clock select and PLL control block.
// Assumes a single system clock domain and a plain register port.
package scspll_pkg;

   // Register word offsets, byte addresses; aliases at +4/+8/+C
   localparam logic [11:0] OSC_CTRL_OFS   = 12'h680;
   localparam logic [11:0] PLL_CTRL_OFS   = 12'h6A0;
   localparam logic [3:0]  ALIAS_CLR      = 4'h4;
   localparam logic [3:0]  ALIAS_SET      = 4'h8;
   localparam logic [3:0]  ALIAS_INV      = 4'hC;

   // Oscillator control field positions
   localparam int FAST_RC_DIVIDER_LSB   = 24;
   localparam int CURSRC_LSB   = 12;
   localparam int REQSRC_LSB   = 8;
   localparam int LOCK_BIT     = 7;
   localparam int SLEEP_BIT    = 4;
   localparam int FAIL_BIT     = 3;
   localparam int SECONDARY_OSC_ENABLE_BIT   = 1;
   localparam int SWREQ_BIT    = 0;

   // PLL control field positions
   localparam int PODIV_LSB    = 24;
   localparam int PMULT_LSB    = 16;
   localparam int PICLK_BIT    = 7;

   // Reset values
   localparam logic [2:0] FAST_RC_DIVIDER_RST   = 3'h0;
   localparam logic [2:0] PODIV_RST    = 3'h0;
   localparam logic [6:0] PMULT_RST    = 7'h01;

   // Source encodings
   localparam logic [2:0] SRC_FRC_DIV  = 3'h0;
   localparam logic [2:0] SRC_PLL      = 3'h1;
   localparam logic [2:0] SRC_PRIMARY_OSCILLATOR     = 3'h2;
   localparam logic [2:0] SRC_SECONDARY_OSCILLATOR     = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSCILLATOR     = 3'h5;

   // Highest legal multiplier code
   localparam logic [6:0] PMULT_MAX    = 7'h06;

   // Cycles the mux stays parked while switching (glitch-free gap)
   localparam int SWITCH_GAP_CYC       = 2;

   typedef enum logic [1:0] {
      SW_IDLE,
      SW_WAIT_RDY,
      SW_GAP,
      SW_DONE
   } scspll_sw_e;

   // Fuse straps sampled at reset release
   typedef struct packed {
      logic [2:0] initial_source;
      logic       two_speed_startup;
      logic       pll_source;
      logic       secondary_oscillator_enable;
   } scspll_fuse_s;

   // Source ready flags, one bit per source in code order, reserved codes skipped
   typedef struct packed {
      logic low_power_rc_oscillator;
      logic secondary_oscillator;
      logic primary_oscillator;
      logic pll;
      logic fast_rc_oscillator;
   } scspll_rdy_s;

endpackage

// ===== sim/scspll_ctrl_sva.sv
// Concurrent checks for the clock select and PLL control block.
// Bound to scspll_ctrl; sees only its ports, single clock domain.
`timescale 1ns/10ps
`default_nettype none
module scspll_ctrl_sva (
   input wire logic                     MCLK_I,
   input wire logic                     RST_N_I,
   input wire logic [11:0]              ADDR_I,
   input wire logic [31:0]              WDATA_I,
   input wire logic                     WR_I,
   input wire logic                     RD_I,
   input wire logic [31:0]              RDATA_O,
   input wire logic                     WR_UNLOCK_I,
   input wire scspll_pkg::scspll_fuse_s FUSE_I,
   input wire scspll_pkg::scspll_rdy_s  SRC_RDY_I,
   input wire logic                     CLK_FAIL_I,
   input wire logic                     WAIT_EXEC_I,
   input wire logic                     SLEEP_ENTER_O,
   input wire logic                     IDLE_ENTER_O,
   input wire logic [2:0]               CLK_MUX_SEL_O,
   input wire logic                     CLK_MUX_PARK_O,
   input wire logic [7:0]               FRC_DIV_RATIO_O,
   input wire logic [7:0]               PLL_OUT_DIV_O,
   input wire logic [4:0]               PLL_MULT_O,
   input wire logic                     PLL_IN_FRC_O,
   input wire logic                     SECONDARY_OSCILLATOR_EN_O,
   input wire logic                     SWITCH_BUSY_O
);
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   // No unlocked write aimed at the PLL word; only such a write may change it
   sequence s_no_pll_wr;
      !(WR_I && WR_UNLOCK_I && ADDR_I[11:4] == scspll_pkg::PLL_CTRL_OFS[11:4]);
   endsequence
   sequence s_one_mode;
      $onehot({SLEEP_ENTER_O, IDLE_ENTER_O});
   endsequence

   a_wait_one_mode: assert property (WAIT_EXEC_I |=> s_one_mode)
      else $error("wait did not give exactly one low-power entry");
   a_no_wait_quiet: assert property (!WAIT_EXEC_I |=> !SLEEP_ENTER_O && !IDLE_ENTER_O)
      else $error("low-power entry without wait");
   a_frc_div_pow: assert property ($onehot(FRC_DIV_RATIO_O))
      else $error("fast rc divide ratio not a power of two");
   a_pll_div_pow: assert property ($onehot(PLL_OUT_DIV_O))
      else $error("pll output divide ratio not a power of two");
   a_mult_legal: assert property (PLL_MULT_O inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18})
      else $error("pll factor outside the legal set");
   a_mux_legal: assert property (CLK_MUX_SEL_O inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
      else $error("clock mux on a reserved source");
   a_mux_moves_busy: assert property ($changed(CLK_MUX_SEL_O) |-> SWITCH_BUSY_O)
      else $error("clock mux moved outside a switch");
   a_park_in_switch: assert property (CLK_MUX_PARK_O |-> SWITCH_BUSY_O)
      else $error("mux parked outside a switch");
   a_pll_hold: assert property (s_no_pll_wr [*2] |=> $stable(PLL_MULT_O))
      else $error("pll factor changed without an accepted write");
endmodule

bind scspll_ctrl scspll_ctrl_sva u_sva (.MCLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
   .RDATA_O, .WR_UNLOCK_I, .FUSE_I, .SRC_RDY_I, .CLK_FAIL_I, .WAIT_EXEC_I, .SLEEP_ENTER_O,
   .IDLE_ENTER_O, .CLK_MUX_SEL_O, .CLK_MUX_PARK_O, .FRC_DIV_RATIO_O, .PLL_OUT_DIV_O,
   .PLL_MULT_O, .PLL_IN_FRC_O, .SECONDARY_OSCILLATOR_EN_O, .SWITCH_BUSY_O);
`default_nettype wire

// ===== sim/scspll_ctrl_tb.sv
// Self-checking bench for the clock select and PLL control block.
// Drives the register port directly; fuses and ready flags are bench straps.
`timescale 1ns/10ps
`default_nettype none
module scspll_ctrl_tb;
   logic                     clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic [11:0]              addr = 12'h000;
   logic [31:0]              wdata = 32'h0;
   logic                     wr = 1'b0;
   logic                     rd = 1'b0;
   logic                     unl = 1'b1;
   logic                     cfail = 1'b0;
   logic                     wexec = 1'b0;
   scspll_pkg::scspll_fuse_s fuse = 6'h23;
   scspll_pkg::scspll_rdy_s  rdy = 5'h00;
   logic [31:0]              rdata;
   logic                     slp, idl, park, pinfrc, secondary_oscillator, busy, seen_park;
   logic [2:0]               mux;
   logic [7:0]               frcd, podv;
   logic [4:0]               mult;
   logic [4:0]               mt [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18, 5'h18};
   int                       fail_count, n_compared;

   always #4 clk = ~clk;

   scspll_ctrl dut (.MCLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .WR_UNLOCK_I(unl), .FUSE_I(fuse), .SRC_RDY_I(rdy),
      .CLK_FAIL_I(cfail), .WAIT_EXEC_I(wexec), .SLEEP_ENTER_O(slp), .IDLE_ENTER_O(idl),
      .CLK_MUX_SEL_O(mux), .CLK_MUX_PARK_O(park), .FRC_DIV_RATIO_O(frcd),
      .PLL_OUT_DIV_O(podv), .PLL_MULT_O(mult), .PLL_IN_FRC_O(pinfrc), .SECONDARY_OSCILLATOR_EN_O(secondary_oscillator),
      .SWITCH_BUSY_O(busy));

   task automatic stop_test;
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [11:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, rdata, e);
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic waitop(input logic e_slp);
      @(posedge clk);
      wexec <= 1'b1;
      @(posedge clk);
      wexec <= 1'b0;
      #1;
      chk("sleep", {31'h0, slp}, {31'h0, e_slp});
      chk("idle", {31'h0, idl}, {31'h0, !e_slp});
   endtask

   // The target stays not ready for a while, so the request must wait
   task automatic swtch(input logic [2:0] e);
      int i;
      @(posedge clk);
      rdy <= 5'h00;
      wreg(12'h688, 32'h1);
      repeat (10) @(posedge clk);
      rdy <= 5'h1F;
      #1;
      chk("pending", {31'h0, busy}, 32'h1);
      seen_park = 1'b0;
      for (i = 0; i < 60 && busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
         seen_park |= park;
      end
      chk("park", {31'h0, seen_park}, 32'h1);
      chk("mux", {29'h0, mux}, {29'h0, e});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test;
   end

   initial begin
      int k;
      logic [31:0] pv;
      fail_count = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      settle;
      chk("secondary_oscillator_en", {31'h0, secondary_oscillator}, 32'h1);
      chk("pll_in", {31'h0, pinfrc}, 32'h1);
      rreg(12'h680, 32'h0000_0402, "osc_rst");
      rreg(12'h6A0, 32'h0001_0080, "pll_rst");
      for (k = 0; k < 8; k++) begin
         wreg(12'h680, 32'hF8FF_F864 | (32'(k) << 24) | 32'h402);
         pv = (32'(k) << 24) | (32'(k) << 16) | 32'h80;
         wreg(12'h6A0, 32'hF880_FF3F | pv);
         settle;
         chk("frc_div", {24'h0, frcd}, 32'h1 << k);
         chk("pll_div", {24'h0, podv}, 32'h1 << k);
         chk("mult", {27'h0, mult}, {27'h0, mt[k]});
         rreg(12'h680, (32'(k) << 24) | 32'h402, "osc_rw");
         if (k < 7) begin
            rreg(12'h6A0, pv, "pll_rw");
         end
      end
      @(posedge clk);
      unl <= 1'b0;
      wreg(12'h680, 32'h0000_0010);
      wreg(12'h6A0, 32'h0);
      unl <= 1'b1;
      settle;
      chk("mult_prot", {27'h0, mult}, 32'h18);
      rreg(12'h680, 32'h0700_0402, "osc_prot");
      rreg(12'h688, 32'h0, "alias_rd");
      rreg(12'h700, 32'h0, "unmapped");
      wreg(12'h688, 32'h10);
      waitop(1'b1);
      wreg(12'h684, 32'h10);
      waitop(1'b0);
      wreg(12'h68C, 32'h0700_0002);
      rreg(12'h680, 32'h0000_0400, "alias_inv");
      settle;
      chk("secondary_oscillator_off", {31'h0, secondary_oscillator}, 32'h0);
      chk("frc_one", {24'h0, frcd}, 32'h1);
      @(posedge clk);
      cfail <= 1'b1;
      @(posedge clk);
      cfail <= 1'b0;
      rreg(12'h680, 32'h0000_0408, "fail_set");
      wreg(12'h684, 32'h8);
      rreg(12'h680, 32'h0000_0400, "fail_clr");
      swtch(3'h4);
      rreg(12'h680, 32'h0000_4400, "cur_secondary_oscillator");
      wreg(12'h680, 32'h0000_0700);
      swtch(3'h0);
      rreg(12'h680, 32'h0000_0700, "cur_frc");
      wreg(12'h6A0, 32'h0006_0000);
      settle;
      chk("pll_primary_oscillator", {31'h0, pinfrc}, 32'h0);
      wreg(12'h680, 32'h0000_0100);
      swtch(3'h1);
      // Leave the PLL before the lock test touches its register
      wreg(12'h680, 32'h0000_0200);
      swtch(3'h2);
      wreg(12'h688, 32'h80);
      wreg(12'h680, 32'h0000_0190);
      wreg(12'h6A0, 32'h0000_0080);
      wreg(12'h688, 32'h1);
      rreg(12'h680, 32'h0000_2290, "locked");
      rreg(12'h6A0, 32'h0006_0000, "pll_locked");
      @(posedge clk);
      rst_n <= 1'b0;
      fuse <= 6'h0D;
      rdy <= 5'h00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      settle;
      rreg(12'h680, 32'h0000_0103, "fuse_rst");
      rreg(12'h6A0, 32'h0001_0000, "pll_fuse");
      stop_test;
   end
endmodule
`default_nettype wire
